/* File: design/gpa_regs.vh */
`ifndef GPA_REGS_VH
`define GPA_REGS_VH
// ----------------------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define GPA_IDX_PIN_VALUE      4'h0
`define GPA_IDX_OUT_LATCH      4'h1
`define GPA_IDX_DIRECTION      4'h2
`define GPA_IDX_ANALOG_SEL     4'h3
`define GPA_IDX_PULLUP_EN      4'h4
`define GPA_IDX_OPEN_DRAIN     4'h5
`define GPA_IDX_SLEW_LIMIT     4'h6
`define GPA_IDX_THRESHOLD      4'h7
`define GPA_IDX_SOURCE_EN      4'h8
`define GPA_IDX_SINK_EN        4'h9
`define GPA_IDX_DRIVE_CONFIG   4'hA
// ----------------------------------------------------------------------------
// Drive configuration fields
// ----------------------------------------------------------------------------
`define GPA_CFG_GLOBAL_BIT     7
`define GPA_CFG_LEVEL_HI       1
`define GPA_CFG_LEVEL_LO       0
`define GPA_CFG_IMPL_MASK      8'h83
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GPA_RST_ONES           8'hFF
`define GPA_RST_ZEROS          8'h00
`define GPA_RST_LEVEL          2'h0
// ----------------------------------------------------------------------------
// Current level codes, one-hot: 1.0, 2.0, 5.0 and 10.0 mA
// ----------------------------------------------------------------------------
`define GPA_LVL_1MA0           4'h1
`define GPA_LVL_2MA0           4'h2
`define GPA_LVL_5MA0           4'h4
`define GPA_LVL_10MA0          4'h8
// ----------------------------------------------------------------------------
// Current level select codes and spare config field
// ----------------------------------------------------------------------------
`define GPA_CODE_1MA0          2'h3
`define GPA_CODE_2MA0          2'h2
`define GPA_CODE_5MA0          2'h1
`define GPA_CFG_SPARE          5'h00
`define GPA_RST_OFF            1'h0
`endif

/* File: design/gpa_pin_sync.v */
`timescale 1ns/1ps
`include "gpa_regs.vh"
// Two-stage synchroniser for the pin inputs
module gpa_pin_sync #(
    parameter WIDTH = 8
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule // gpa_pin_sync

/* File: design/gpa_port.v */
`timescale 1ns/1ps
`include "gpa_regs.vh"
module gpa_port #(
    parameter PINS = 8
) (
    input  wire            clk_i,
    input  wire            rst_i,
    input  wire            wb_cyc_i,
    input  wire            wb_stb_i,
    input  wire            wb_we_i,
    input  wire [5:0]      wb_adr_i,
    input  wire [3:0]      wb_sel_i,
    input  wire [31:0]     wb_dat_i,
    output reg  [31:0]     wb_dat_o,
    output reg             wb_ack_o,
    input  wire [PINS-1:0] pin_in_i,
    output reg  [PINS-1:0] pin_out_o,
    output reg  [PINS-1:0] pin_oe_o,
    input  wire [PINS-1:0] i2c_own_i,
    output reg  [PINS-1:0] pullup_on_o,
    output reg  [PINS-1:0] slew_limit_o,
    output reg  [PINS-1:0] schmitt_sel_o,
    output reg  [PINS-1:0] analog_sel_o,
    output reg  [PINS-1:0] digital_in_o,
    output reg  [PINS-1:0] source_ctl_o,
    output reg  [PINS-1:0] sink_ctl_o,
    output reg  [3:0]      current_level_o
);
    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    reg  [PINS-1:0] port_output_latch_ff;
    reg  [PINS-1:0] port_direction_ff;
    reg  [PINS-1:0] port_analog_select_ff;
    reg  [PINS-1:0] port_pullup_enable_ff;
    reg  [PINS-1:0] port_open_drain_select_ff;
    reg  [PINS-1:0] port_slew_limit_select_ff;
    reg  [PINS-1:0] port_threshold_select_ff;
    reg  [PINS-1:0] pin_source_current_enable_ff;
    reg  [PINS-1:0] pin_sink_current_enable_ff;
    reg             current_drive_global_enable_ff;
    reg  [1:0]      current_level_select_ff;
    wire [PINS-1:0] pin_sync;
    wire [PINS-1:0] port_pin_value;
    wire [3:0]      reg_idx;
    wire            bus_req;
    wire            wr_en;
    wire            lane0;
    wire [7:0]      wr_byte;
    wire            adr_hit;
    reg  [7:0]      nxt_rd_byte;
    reg  [3:0]      nxt_level;
    wire [PINS-1:0] nxt_pin_out;
    wire [PINS-1:0] nxt_pin_oe;
    wire [PINS-1:0] nxt_pullup;
    wire [PINS-1:0] nxt_source;
    wire [PINS-1:0] nxt_sink;

    assign reg_idx = wb_adr_i[5:2];
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign lane0   = wb_sel_i[0];
    assign wr_en   = bus_req & wb_we_i & lane0;
    assign wr_byte = wb_dat_i[7:0];
    assign adr_hit = (reg_idx <= `GPA_IDX_DRIVE_CONFIG);

    // ------------------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------------------
    // synchronise pin levels
    gpa_pin_sync #(
        .WIDTH   (PINS)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pin_in_i),
        .sync_o  (pin_sync)
    );

    assign port_pin_value = pin_sync & ~port_analog_select_ff;

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            port_output_latch_ff           <= `GPA_RST_ZEROS;
            port_direction_ff              <= `GPA_RST_ONES;
            port_pullup_enable_ff          <= `GPA_RST_ZEROS;
            port_open_drain_select_ff      <= `GPA_RST_ZEROS;
            port_analog_select_ff          <= `GPA_RST_ONES;
            port_slew_limit_select_ff      <= `GPA_RST_ONES;
            port_threshold_select_ff       <= `GPA_RST_ONES;
            pin_source_current_enable_ff   <= `GPA_RST_ZEROS;
            pin_sink_current_enable_ff     <= `GPA_RST_ZEROS;
            current_drive_global_enable_ff <= `GPA_RST_OFF;
            current_level_select_ff        <= `GPA_RST_LEVEL;
        end else if (wr_en) begin
            case (reg_idx)
                `GPA_IDX_PIN_VALUE:  port_output_latch_ff <= wr_byte;
                `GPA_IDX_OUT_LATCH:  port_output_latch_ff <= wr_byte;
                `GPA_IDX_DIRECTION:  port_direction_ff <= wr_byte;
                `GPA_IDX_ANALOG_SEL: port_analog_select_ff <= wr_byte;
                `GPA_IDX_PULLUP_EN:  port_pullup_enable_ff <= wr_byte;
                `GPA_IDX_OPEN_DRAIN: port_open_drain_select_ff <= wr_byte;
                `GPA_IDX_SLEW_LIMIT: port_slew_limit_select_ff <= wr_byte;
                `GPA_IDX_THRESHOLD:  port_threshold_select_ff <= wr_byte;
                `GPA_IDX_SOURCE_EN:  pin_source_current_enable_ff <= wr_byte;
                `GPA_IDX_SINK_EN:    pin_sink_current_enable_ff <= wr_byte;
                `GPA_IDX_DRIVE_CONFIG: begin
                    current_drive_global_enable_ff <= wr_byte[`GPA_CFG_GLOBAL_BIT];
                    current_level_select_ff <=
                        wr_byte[`GPA_CFG_LEVEL_HI:`GPA_CFG_LEVEL_LO];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------------
    always @* begin
        nxt_rd_byte = 8'h00;
        case (reg_idx)
            `GPA_IDX_PIN_VALUE:  nxt_rd_byte = port_pin_value;
            `GPA_IDX_OUT_LATCH:  nxt_rd_byte = port_output_latch_ff;
            `GPA_IDX_DIRECTION:  nxt_rd_byte = port_direction_ff;
            `GPA_IDX_ANALOG_SEL: nxt_rd_byte = port_analog_select_ff;
            `GPA_IDX_PULLUP_EN:  nxt_rd_byte = port_pullup_enable_ff;
            `GPA_IDX_OPEN_DRAIN: nxt_rd_byte = port_open_drain_select_ff;
            `GPA_IDX_SLEW_LIMIT: nxt_rd_byte = port_slew_limit_select_ff;
            `GPA_IDX_THRESHOLD:  nxt_rd_byte = port_threshold_select_ff;
            `GPA_IDX_SOURCE_EN:  nxt_rd_byte = pin_source_current_enable_ff;
            `GPA_IDX_SINK_EN:    nxt_rd_byte = pin_sink_current_enable_ff;
            `GPA_IDX_DRIVE_CONFIG: nxt_rd_byte =
                {current_drive_global_enable_ff, `GPA_CFG_SPARE, current_level_select_ff}
                & `GPA_CFG_IMPL_MASK;
            default: nxt_rd_byte = 8'h00;
        endcase
    end

    // Single wait-free ack; unmapped indices read zero and ignore writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req & ~wb_we_i)
                wb_dat_o <= {24'h00_0000, adr_hit ? nxt_rd_byte : 8'h00};
        end
    end

    // ------------------------------------------------------------------------
    // Current level decode
    // ------------------------------------------------------------------------
    // level code decode
    always @* begin
        case (current_level_select_ff)
            `GPA_CODE_1MA0: nxt_level = `GPA_LVL_1MA0;
            `GPA_CODE_2MA0: nxt_level = `GPA_LVL_2MA0;
            `GPA_CODE_5MA0: nxt_level = `GPA_LVL_5MA0;
            default:        nxt_level = `GPA_LVL_10MA0;
        endcase
    end

    // ------------------------------------------------------------------------
    // Per-pin drive decode
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1) begin : g_pin
            wire od_mode;
            assign od_mode = port_open_drain_select_ff[g] | i2c_own_i[g];
            assign nxt_pin_out[g] = ~od_mode & port_output_latch_ff[g];
            assign nxt_pin_oe[g]  = ~port_direction_ff[g]
                                    & ~(od_mode & port_output_latch_ff[g]);
            assign nxt_pullup[g]  = port_pullup_enable_ff[g] & port_direction_ff[g];
            assign nxt_source[g]  = current_drive_global_enable_ff
                                    & pin_source_current_enable_ff[g];
            assign nxt_sink[g]    = current_drive_global_enable_ff
                                    & pin_sink_current_enable_ff[g];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------------
    // One process drives every pin-side output vector, keeping a single driver per port
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_o       <= `GPA_RST_ZEROS;
            pin_oe_o        <= `GPA_RST_ZEROS;
            pullup_on_o     <= `GPA_RST_ZEROS;
            slew_limit_o    <= `GPA_RST_ONES;
            schmitt_sel_o   <= `GPA_RST_ONES;
            analog_sel_o    <= `GPA_RST_ONES;
            digital_in_o    <= `GPA_RST_ZEROS;
            source_ctl_o    <= `GPA_RST_ZEROS;
            sink_ctl_o      <= `GPA_RST_ZEROS;
            current_level_o <= `GPA_LVL_10MA0;
        end else begin
            pin_out_o       <= nxt_pin_out;
            pin_oe_o        <= nxt_pin_oe;
            pullup_on_o     <= nxt_pullup;
            slew_limit_o    <= port_slew_limit_select_ff;
            schmitt_sel_o   <= port_threshold_select_ff;
            analog_sel_o    <= port_analog_select_ff;
            digital_in_o    <= port_pin_value;
            source_ctl_o    <= nxt_source;
            sink_ctl_o      <= nxt_sink;
            current_level_o <= nxt_level;
        end
    end
endmodule // gpa_port

/* File: tb/gpa_port_assertions.sv */
`timescale 1ns/1ps
module gpa_port_assertions #(
    parameter PINS = 8
) (
    input wire            clk_i,
    input wire            rst_i,
    input wire            wb_cyc_i,
    input wire            wb_stb_i,
    input wire            wb_we_i,
    input wire [5:0]      wb_adr_i,
    input wire [31:0]     wb_dat_o,
    input wire            wb_ack_o,
    input wire [PINS-1:0] pin_in_i,
    input wire [PINS-1:0] pin_out_o,
    input wire [PINS-1:0] pin_oe_o,
    input wire [PINS-1:0] i2c_own_i,
    input wire [PINS-1:0] pullup_on_o,
    input wire [PINS-1:0] analog_sel_o,
    input wire [PINS-1:0] digital_in_o,
    input wire [3:0]      current_level_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
    property p_i2c_od; ((pin_oe_o & pin_out_o & $past(i2c_own_i)) == 8'h00); endproperty
    a_i2c_od: assert property (p_i2c_od) else $error("owned pin drives high");
    property p_pull_out; (pullup_on_o & pin_oe_o) == 8'h00; endproperty
    a_pull_out: assert property (p_pull_out) else $error("pull-up on driven pin");
    property p_ana_zero; (digital_in_o & analog_sel_o) == 8'h00; endproperty
    a_ana_zero: assert property (p_ana_zero) else $error("analog pin reads one");
    property p_sync;
        ($stable(pin_in_i) && $stable(analog_sel_o)) [*5]
        |-> ((pin_in_i ^ digital_in_o) & ~analog_sel_o) == 8'h00;
    endproperty
    a_sync: assert property (p_sync) else $error("digital input stale");
    property p_rst_dir; $fell(rst_i) |-> pin_oe_o == 8'h00 && pullup_on_o == 8'h00; endproperty
    a_rst_dir: assert property (p_rst_dir) else $error("pins not inputs after reset");
    property p_rst_ana; $fell(rst_i) |-> analog_sel_o == 8'hFF && digital_in_o == 8'h00; endproperty
    a_rst_ana: assert property (p_rst_ana) else $error("analog select not set");
    property p_cfg_rd;
        wb_ack_o && $past(wb_adr_i) == 6'h28 && !$past(wb_we_i) |-> wb_dat_o[6:2] == 5'h00;
    endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("config spare bits set");
    property p_lvl; $onehot(current_level_o); endproperty
    a_lvl: assert property (p_lvl) else $error("level not one-hot");
endmodule // gpa_port_assertions
bind gpa_port gpa_port_assertions #(.PINS(PINS)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .i2c_own_i(i2c_own_i), .pullup_on_o(pullup_on_o),
    .analog_sel_o(analog_sel_o), .digital_in_o(digital_in_o),
    .current_level_o(current_level_o));

/* File: tb/gpa_pin_model.sv */
`timescale 1ns/1ps
module gpa_pin_model (
    input  wire       clk_i,
    input  wire [7:0] out_i,
    input  wire [7:0] oe_i,
    input  wire [7:0] pull_i,
    input  wire [7:0] ext_en_i,
    input  wire [7:0] ext_val_i,
    output wire [7:0] lvl_o
);
    reg  [7:0] last_ff = 8'h00;
    wire [7:0] held;
    // Released unpulled lines show the inverse of the last driven level
    assign held  = oe_i | ext_en_i;
    assign lvl_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
                 | (~held & (pull_i | ~last_ff));
    always @(posedge clk_i) last_ff <= (held & lvl_o) | (~held & last_ff);
endmodule // gpa_pin_model

/* File: tb/gpa_port_tb_top.sv */
`timescale 1ns/1ps
`include "gpa_regs.vh"
`define CHK(a, b) begin n_compared = n_compared + 1; if ((a) !== (b)) begin \
    err_total = err_total + 1; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module gpa_port_tb_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [7:0]  own = 8'h00, ext_en = 8'h00, ext_val = 8'h00, q, d, eoe;
    logic [7:0]  v [0:7];
    logic [3:0]  k;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o;
    wire  [7:0]  lvl, pin_out_o, pin_oe_o, pullup_on_o, slew_limit_o, schmitt_sel_o;
    wire  [7:0]  analog_sel_o, digital_in_o, source_ctl_o, sink_ctl_o;
    wire  [3:0]  current_level_o;
    integer      err_total = 0, n_compared = 0, seed = 69, i, j;
    always #25 clk_i = ~clk_i;
    gpa_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pin_in_i(lvl), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .i2c_own_i(own),
        .pullup_on_o(pullup_on_o), .slew_limit_o(slew_limit_o), .schmitt_sel_o(schmitt_sel_o),
        .analog_sel_o(analog_sel_o), .digital_in_o(digital_in_o), .source_ctl_o(source_ctl_o),
        .sink_ctl_o(sink_ctl_o), .current_level_o(current_level_o));
    gpa_pin_model u_pins (.clk_i(clk_i), .out_i(pin_out_o), .oe_i(pin_oe_o),
        .pull_i(pullup_on_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(lvl));
    task automatic wb(input logic w, input logic [3:0] s, input logic [3:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= {idx, 2'b00};
        dat <= {24'h00_0000, wd};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        rd = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    function automatic logic [7:0] rst_val(input logic [3:0] idx);
        rst_val = (idx == 4'h2 || idx == 4'h3 || idx == 4'h6 || idx == 4'h7) ? 8'hFF : 8'h00;
    endfunction
    task report_and_stop;
        $display("compared=%0d errors=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        err_total = err_total + 1;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 16; i++) begin
            wb(1'b0, 4'h1, 4'(i), 8'h00, q);
            `CHK(q, rst_val(4'(i)))
        end
        wb(1'b1, 4'hE, `GPA_IDX_PULLUP_EN, 8'hFF, q);
        wb(1'b1, 4'h1, 4'hC, 8'hFF, q);
        wb(1'b0, 4'h1, `GPA_IDX_PULLUP_EN, 8'h00, q);
        `CHK(q, 8'h00)
        wb(1'b0, 4'h1, 4'hC, 8'h00, q);
        `CHK(q, 8'h00)
        // random readback, per-pin enables left clear
        for (i = 0; i < 40; i++) begin
            k = 4'h1 + 4'($unsigned($random(seed)) % 8);
            if (k == 4'h8) k = `GPA_IDX_DRIVE_CONFIG;
            d = 8'($random(seed));
            wb(1'b1, 4'h1, k, d, q);
            wb(1'b0, 4'h1, k, 8'h00, q);
            `CHK(q, (k == `GPA_IDX_DRIVE_CONFIG) ? (d & `GPA_CFG_IMPL_MASK) : d)
        end
        // drive, pull-up, slew, threshold and analog settings change with random I2C ownership of the pins
        for (i = 0; i < 24; i++) begin
            own <= 8'h00;
            for (j = 1; j < 8; j++)
                v[j] = 8'($random(seed));
            // analog pins kept as inputs on half the passes
            if (!i[1]) v[2] = v[2] | v[3];
            for (j = 1; j < 8; j++)
                wb(1'b1, 4'h1, (j == 1 && i[0]) ? 4'h0 : 4'(j), v[j], q);
            d = 8'($random(seed));
            own <= d;
            eoe = ~v[2] & ~((v[5] | d) & v[1]);
            ext_en <= ~eoe;
            ext_val <= 8'($random(seed));
            repeat (6) @(posedge clk_i);
            `CHK(pin_oe_o, eoe)
            `CHK(pin_out_o & eoe, v[1] & eoe)
            `CHK(pullup_on_o, v[4] & v[2])
            `CHK(slew_limit_o, v[6])
            `CHK(schmitt_sel_o, v[7])
            `CHK(analog_sel_o, v[3])
            `CHK(digital_in_o, ((eoe & v[1]) | (~eoe & ext_val)) & ~v[3])
            wb(1'b0, 4'h1, `GPA_IDX_PIN_VALUE, 8'h00, q);
            `CHK(q, ((eoe & v[1]) | (~eoe & ext_val)) & ~v[3])
            wb(1'b0, 4'h1, `GPA_IDX_OUT_LATCH, 8'h00, q);
            `CHK(q, v[1])
        end
        // global enable set before any per-pin enable
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            wb(1'b1, 4'h1, `GPA_IDX_DRIVE_CONFIG, {6'h20, 2'(i)}, q);
            wb(1'b1, 4'h1, `GPA_IDX_SOURCE_EN, d, q);
            wb(1'b1, 4'h1, `GPA_IDX_SINK_EN, ~d, q);
            @(posedge clk_i);
            `CHK(current_level_o, 4'h8 >> i)
            `CHK(source_ctl_o, d)
            `CHK(sink_ctl_o, ~d)
        end
        // per-pin enables cleared before the global one
        wb(1'b1, 4'h1, `GPA_IDX_SOURCE_EN, 8'h00, q);
        wb(1'b1, 4'h1, `GPA_IDX_SINK_EN, 8'h00, q);
        wb(1'b1, 4'h1, `GPA_IDX_DRIVE_CONFIG, 8'h00, q);
        @(posedge clk_i);
        `CHK(source_ctl_o | sink_ctl_o, 8'h00)
        report_and_stop;
    end
endmodule // gpa_port_tb_top
